// ### include/bcm_pkg.sv
package bcm_pkg;
	// Depth of every pin synchroniser; two flops before any logic looks.
	localparam int unsigned SYNC_STAGES = 2;

	// Reset values of the registered outputs.
	localparam logic RST_TICK = 1'b0;
	localparam logic RST_STALL = 1'b0;
	localparam logic RST_READY = 1'b0;
	localparam logic RST_ACK = 1'b0;

	// Pin order inside the synchroniser vector.
	localparam int unsigned PIN_BUS_CLK = 0;
	localparam int unsigned PIN_FAST_CLK = 1;
	localparam int unsigned PIN_WAIT = 2;
	localparam int unsigned PIN_SINGLE = 3;
	localparam int unsigned PIN_SYNC = 4;
	localparam int unsigned PIN_COUNT = 5;

	typedef enum logic [1:0] {
		BCM_BUS_IDLE = 2'h0,
		BCM_BUS_ADDR = 2'h1,
		BCM_BUS_DATA = 2'h3,
		BCM_BUS_DONE = 2'h2
	} bcm_bus_state_t;

	typedef enum logic [1:0] {
		BCM_SRC_FAST = 2'h0,
		BCM_SRC_TO_BUS = 2'h1,
		BCM_SRC_BUS = 2'h3,
		BCM_SRC_TO_FAST = 2'h2
	} bcm_src_state_t;

	typedef struct packed {
		logic single_clock;
		logic sync_mode;
	} bcm_mode_t;

	typedef struct packed {
		logic valid;
		logic write;
	} bcm_req_t;
endpackage : bcm_pkg

// ### hw/bcm_pin_sync.sv
`timescale 1ns/1ps
module bcm_pin_sync #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned STAGES = bcm_pkg::SYNC_STAGES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] rise_o
);
	if (STAGES < 2 || WIDTH < 1) begin : g_bad_cfg
		$error("bcm_pin_sync needs at least two stages and one pin");
	end

	logic [WIDTH-1:0] stage_r [STAGES];
	logic [WIDTH-1:0] stage_nxt [STAGES];
	logic [WIDTH-1:0] last_r;
	logic [WIDTH-1:0] last_nxt;

	// Only the last stage is looked at; the first one may be metastable.
	always_comb begin
		stage_nxt[0] = pin_i;
		for (int i = 1; i < STAGES; i++) begin
			stage_nxt[i] = stage_r[i-1];
		end
		last_nxt = stage_r[STAGES-1];
	end

	// The stages follow the pins through reset and the edge memory is held high there,
	// so a clock pin that happens to be high when reset ends gives no false edge.
	always_ff @(posedge clk_i) begin
		stage_r <= stage_nxt;
		if (rst_i) begin
			last_r <= '1;
		end else begin
			last_r <= last_nxt;
		end
	end

	assign level_o = stage_r[STAGES-1];
	assign rise_o = stage_r[STAGES-1] & ~last_r;
endmodule : bcm_pin_sync

// ### hw/bcm_clock_ctrl.sv
`timescale 1ns/1ps
// Function
// - Single-clock: bus clock drives core, cache, bus.
// - Single-clock ignores fast clock and sub-mode select.
// - Wait stretches access by whole bus cycles.
// - Core sees every bus cycle despite wait.
// - Only buffered writes overlap core execution.
// - Reads stall the core until bus completes.
// - Dual-clock: bus from bus clock, core fast.
// - Dual-clock accepts wait or stretched bus phases.
// - Sub-mode select: high synchronous, low asynchronous.
// - Asynchronous switch costs up to one destination period.
// - Fully static; clocks may halt indefinitely.
module bcm_clock_ctrl (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic BUS_CLK_I,
	input wire logic FAST_CORE_CLOCK_I,
	input wire logic SINGLE_CLOCK_SELECT_I,
	input wire logic SYNC_ASYNC_SELECT_I,
	input wire logic BUS_WAIT_I,
	input wire logic REQ_VALID_I,
	input wire logic REQ_WRITE_I,
	output logic REQ_READY_O,
	output logic REQ_ACK_O,
	output logic CORE_STALL_O,
	output logic CORE_TICK_O,
	output logic BUS_TICK_O,
	output logic BUS_BUSY_O,
	output logic CORE_ON_BUS_CLK_O,
	output logic SINGLE_MODE_O
);
	logic [bcm_pkg::PIN_COUNT-1:0] pin_lvl;
	logic [bcm_pkg::PIN_COUNT-1:0] pin_rise;

	// All five pins belong to other clock domains and pass the synchroniser.
	bcm_pin_sync #(
		.WIDTH(bcm_pkg::PIN_COUNT),
		.STAGES(bcm_pkg::SYNC_STAGES)
	) u_pins (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.pin_i({SYNC_ASYNC_SELECT_I, SINGLE_CLOCK_SELECT_I, BUS_WAIT_I, FAST_CORE_CLOCK_I, BUS_CLK_I}),
		.level_o(pin_lvl),
		.rise_o(pin_rise)
	);

	bcm_pkg::bcm_mode_t mode;
	bcm_pkg::bcm_req_t req;
	logic bus_edge;
	logic fast_edge;
	logic wait_lvl;

	always_comb begin
		mode.single_clock = pin_lvl[bcm_pkg::PIN_SINGLE];
		// The sub-mode select has no meaning with one clock.
		mode.sync_mode = pin_lvl[bcm_pkg::PIN_SYNC] & ~pin_lvl[bcm_pkg::PIN_SINGLE];
		req.valid = REQ_VALID_I;
		req.write = REQ_WRITE_I;
		bus_edge = pin_rise[bcm_pkg::PIN_BUS_CLK];
		fast_edge = pin_rise[bcm_pkg::PIN_FAST_CLK] & ~mode.single_clock;
		// Wait settles while the bus clock is low, so it is stable at the rising edge.
		wait_lvl = pin_lvl[bcm_pkg::PIN_WAIT];
	end

	// Bus access sequencer: address cycle, then memory cycle stretched by wait.
	bcm_pkg::bcm_bus_state_t bus_r, bus_nxt;
	logic write_r, write_nxt;
	logic ready_r, ready_nxt;
	logic ack_r, ack_nxt;
	logic stall_r, stall_nxt;
	logic bus_tick_r, bus_tick_nxt;

	always_comb begin
		bus_nxt = bus_r;
		write_nxt = write_r;
		ready_nxt = 1'b0;
		ack_nxt = 1'b0;
		stall_nxt = stall_r;
		// The bus tick marks only bus edges not held by wait; the address cycle advances on any bus edge.
		bus_tick_nxt = bus_edge & ~wait_lvl;
		unique case (bus_r)
			bcm_pkg::BCM_BUS_IDLE: begin
				ready_nxt = 1'b1;
				if (req.valid && ready_r) begin
					ready_nxt = 1'b0;
					write_nxt = req.write;
					bus_nxt = bcm_pkg::BCM_BUS_ADDR;
					// A buffered write is taken at once and the core runs on.
					ack_nxt = req.write;
					// A read holds the core until its data returns.
					stall_nxt = ~req.write;
				end
			end
			bcm_pkg::BCM_BUS_ADDR: begin
				if (bus_edge) begin
					bus_nxt = bcm_pkg::BCM_BUS_DATA;
				end
			end
			bcm_pkg::BCM_BUS_DATA: begin
				// Each edge with wait high adds exactly one whole bus cycle.
				if (bus_edge && !wait_lvl) begin
					bus_nxt = bcm_pkg::BCM_BUS_DONE;
				end
			end
			bcm_pkg::BCM_BUS_DONE: begin
				bus_nxt = bcm_pkg::BCM_BUS_IDLE;
				ack_nxt = ~write_r;
				stall_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			bus_r <= bcm_pkg::BCM_BUS_IDLE;
			write_r <= 1'b0;
			ready_r <= bcm_pkg::RST_READY;
			ack_r <= bcm_pkg::RST_ACK;
			stall_r <= bcm_pkg::RST_STALL;
			bus_tick_r <= bcm_pkg::RST_TICK;
		end else begin
			bus_r <= bus_nxt;
			write_r <= write_nxt;
			ready_r <= ready_nxt;
			ack_r <= ack_nxt;
			stall_r <= stall_nxt;
			bus_tick_r <= bus_tick_nxt;
		end
	end

	// Core clock source. In single-clock mode or while a read waits the core follows
	// the bus clock, otherwise the fast clock. Handover in asynchronous mode waits for the
	// synchronised edge of the destination clock, so no tick is ever cut short.
	bcm_pkg::bcm_src_state_t src_r, src_nxt;
	logic core_tick_r, core_tick_nxt;
	logic want_bus;

	always_comb begin
		src_nxt = src_r;
		core_tick_nxt = 1'b0;
		want_bus = stall_r;
		if (mode.single_clock) begin
			// One clock runs everything, wait or not.
			src_nxt = bcm_pkg::BCM_SRC_BUS;
			core_tick_nxt = bus_edge;
		end else begin
			unique case (src_r)
				bcm_pkg::BCM_SRC_FAST: begin
					core_tick_nxt = fast_edge;
					if (want_bus) begin
						// Synchronous clocks need no resync penalty.
						src_nxt = mode.sync_mode ? bcm_pkg::BCM_SRC_BUS : bcm_pkg::BCM_SRC_TO_BUS;
					end
				end
				bcm_pkg::BCM_SRC_TO_BUS: begin
					// Delay of zero to one bus period.
					if (bus_edge) begin
						src_nxt = bcm_pkg::BCM_SRC_BUS;
						core_tick_nxt = 1'b1;
					end
				end
				bcm_pkg::BCM_SRC_BUS: begin
					core_tick_nxt = bus_edge;
					if (!want_bus) begin
						src_nxt = mode.sync_mode ? bcm_pkg::BCM_SRC_FAST : bcm_pkg::BCM_SRC_TO_FAST;
					end
				end
				bcm_pkg::BCM_SRC_TO_FAST: begin
					// Delay of zero to one fast period.
					if (fast_edge) begin
						src_nxt = bcm_pkg::BCM_SRC_FAST;
						core_tick_nxt = 1'b1;
					end
				end
			endcase
		end
	end

	// The handover states move only on seen edges and never time out, so halted clocks
	// freeze everything intact.
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			src_r <= bcm_pkg::BCM_SRC_FAST;
			core_tick_r <= bcm_pkg::RST_TICK;
		end else begin
			src_r <= src_nxt;
			core_tick_r <= core_tick_nxt;
		end
	end

	logic busy_r, busy_nxt;
	logic on_bus_r, on_bus_nxt;
	logic single_r, single_nxt;

	always_comb begin
		busy_nxt = (bus_nxt != bcm_pkg::BCM_BUS_IDLE);
		on_bus_nxt = (src_nxt == bcm_pkg::BCM_SRC_BUS);
		single_nxt = mode.single_clock;
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			busy_r <= 1'b0;
			on_bus_r <= 1'b0;
			single_r <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
			on_bus_r <= on_bus_nxt;
			single_r <= single_nxt;
		end
	end

	assign REQ_READY_O = ready_r;
	assign REQ_ACK_O = ack_r;
	assign CORE_STALL_O = stall_r;
	assign CORE_TICK_O = core_tick_r;
	assign BUS_TICK_O = bus_tick_r;
	assign BUS_BUSY_O = busy_r;
	assign CORE_ON_BUS_CLK_O = on_bus_r;
	assign SINGLE_MODE_O = single_r;
endmodule : bcm_clock_ctrl

// ### testbench/bcm_clock_ctrl_props.sv
`timescale 1ns/1ps
module bcm_clock_ctrl_props (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic BUS_WAIT_I,
	input wire logic REQ_VALID_I,
	input wire logic REQ_WRITE_I,
	input wire logic REQ_READY_O,
	input wire logic REQ_ACK_O,
	input wire logic CORE_STALL_O,
	input wire logic CORE_TICK_O,
	input wire logic BUS_TICK_O,
	input wire logic BUS_BUSY_O,
	input wire logic CORE_ON_BUS_CLK_O,
	input wire logic SINGLE_MODE_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	wire logic take = REQ_VALID_I && REQ_READY_O;
	property p_wr; take && REQ_WRITE_I |=> REQ_ACK_O && !CORE_STALL_O; endproperty
	a_wr: assert property (p_wr) else $error("write ack late");
	property p_rd; take && !REQ_WRITE_I |=> (CORE_STALL_O && !REQ_ACK_O) [*2]; endproperty
	a_rd: assert property (p_rd) else $error("read not stalled");
	property p_ack; REQ_ACK_O |=> !REQ_ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("ack too long");
	property p_st; CORE_STALL_O |-> !REQ_READY_O; endproperty
	a_st: assert property (p_st) else $error("ready in stall");
	property p_one; SINGLE_MODE_O && BUS_TICK_O |-> CORE_TICK_O; endproperty
	a_one: assert property (p_one) else $error("core tick lost");
	property p_wt; BUS_TICK_O |-> !$past(BUS_WAIT_I, 2); endproperty
	a_wt: assert property (p_wt) else $error("tick in wait");
	property p_tb; !SINGLE_MODE_O && take && !REQ_WRITE_I |-> ##[1:40] CORE_ON_BUS_CLK_O; endproperty
	a_tb: assert property (p_tb) else $error("no bus source");
	property p_bk; !SINGLE_MODE_O && $fell(BUS_BUSY_O) |-> ##[0:20] !CORE_ON_BUS_CLK_O; endproperty
	a_bk: assert property (p_bk) else $error("no fast return");
endmodule : bcm_clock_ctrl_props
bind bcm_clock_ctrl bcm_clock_ctrl_props i_bcm_clock_ctrl_props (.*);

// ### testbench/bcm_far_side.sv
`timescale 1ns/1ps
module bcm_far_side (
	input wire logic run_i,
	input wire logic wait_i,
	output logic bus_clk_o = 1'h0,
	output logic fast_clk_o = 1'h0,
	output logic wait_o = 1'h0
);
	// Fast clock at twice the bus rate, so it leads in every single cycle.
	always #31.25 fast_clk_o = ~fast_clk_o;
	always @(negedge fast_clk_o) if (run_i || bus_clk_o) bus_clk_o <= ~bus_clk_o;
	always @(negedge bus_clk_o) wait_o <= #20 wait_i;
endmodule : bcm_far_side

// ### testbench/bcm_clock_ctrl_test.sv
`timescale 1ns/1ps
module bcm_clock_ctrl_test;
	logic clk = 1'h0, rst = 1'h1, run = 1'h1, wq = 1'h0, sgl = 1'h0, syn = 1'h0, vld = 1'h0, wr = 1'h0;
	logic ok, onb, bclk, fast_core_clock, wt, rdy, ack, stl, ct, bt, onbus, smode, busy;
	int miscompares = 0, check_count = 0, lat, nc, nb;
	always #5 clk = ~clk;
	bcm_far_side i_bcm_far_side (.run_i(run), .wait_i(wq), .bus_clk_o(bclk), .fast_clk_o(fast_core_clock), .wait_o(wt));
	bcm_clock_ctrl i_bcm_clock_ctrl (.CORE_CLK_I(clk), .RST_I(rst), .BUS_CLK_I(bclk), .BUS_WAIT_I(wt),
		.FAST_CORE_CLOCK_I(fast_core_clock & ~sgl), .SINGLE_CLOCK_SELECT_I(sgl), .SYNC_ASYNC_SELECT_I(syn),
		.REQ_VALID_I(vld), .REQ_WRITE_I(wr), .REQ_READY_O(rdy), .REQ_ACK_O(ack), .CORE_STALL_O(stl),
		.CORE_TICK_O(ct), .BUS_TICK_O(bt), .BUS_BUSY_O(busy), .CORE_ON_BUS_CLK_O(onbus), .SINGLE_MODE_O(smode));
	task close_out;
		if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	task chk_n(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("[ERR] %0t value %0d off", $time, got);
		end
	endtask : chk_n
	task do_reset(input logic s, input logic y);
		@(posedge clk);
		{rst, sgl, syn} <= {1'h1, s, y};
		repeat (8) @(posedge clk);
		rst <= 1'h0;
	endtask : do_reset
	task ticks(input int n);
		{nc, nb} = 64'h0;
		repeat (n) begin
			@(negedge clk);
			nc += ct;
			nb += bt;
		end
	endtask : ticks
	task access(input logic w);
		for (lat = 0; lat < 99 && rdy !== 1'h1; lat++) @(negedge clk);
		chk_n(lat, 0, 98);
		@(posedge clk);
		vld <= 1'h1;
		wr <= w;
		@(posedge clk);
		vld <= 1'h0;
		{ok, onb} = 2'h2;
		for (lat = 1; lat < 999; lat++) begin
			@(negedge clk);
			// Stall and busy both drop with a read's ack; a write is acked while still busy.
			ok &= stl === (ack !== 1'h1 && !w);
			ok &= busy === (ack !== 1'h1 || w);
			if (ack === 1'h1) break;
			onb |= onbus;
		end
		chk_n(lat, 1, 998);
		if (lat == 999) close_out();
	endtask : access
	task t_sync;
		do_reset(1'h0, 1'h1);
		ticks(400);
		chk_n(nc, 60, 68);
		chk_n(nb, 30, 34);
		run <= 1'h0;
		ticks(320);
		chk_n(nb, 0, 1);
		chk_n(nc, 48, 54);
		run <= 1'h1;
		access(1'h1);
		chk_n(lat, 1, 1);
		chk_n(ok, 1, 1);
		access(1'h0);
		chk_n(lat, 3, 60);
		chk_n(ok, 1, 1);
		chk_n(onb, 1, 1);
	endtask : t_sync
	task t_async;
		do_reset(1'h0, 1'h0);
		wq <= 1'h1;
		ticks(30);
		fork
			begin
				repeat (80) @(posedge clk);
				wq <= 1'h0;
			end
		join_none
		access(1'h0);
		chk_n(lat, 70, 300);
		chk_n(onb, 1, 1);
	endtask : t_async
	task t_single;
		do_reset(1'h1, 1'h0);
		ticks(250);
		chk_n(nc, 18, 22);
		chk_n(nc - nb, 0, 0);
		wq <= 1'h1;
		ticks(420);
		chk_n(nc, 31, 36);
		chk_n(nb, 0, 2);
		chk_n(smode, 1, 1);
	endtask : t_single
	initial begin
		t_sync();
		t_async();
		t_single();
		close_out();
	end
endmodule : bcm_clock_ctrl_test
